// file: core/sepi_image.sv
// Cyclic safety input image builder with preset handshake
`timescale 1ns/1ps
`include "sepi_params.svh"

module sepi_image
    import sepi_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [31:0] vel_cw_meas,
    input  wire logic        dir_forward,
    input  wire logic [2:0]  idle_tolerance,
    input  wire logic [31:0] rev_meas,
    input  wire logic [12:0] single_turn_meas,
    input  wire logic        other_preset_busy,
    input  wire logic        preset_done,
    input  wire sepi_word_t  preset_control_word,
    input  wire sepi_word_t  reserved_control_word,
    input  wire sepi_word_t  preset_rev_word,
    input  wire sepi_word_t  preset_st_word,
    input  wire logic        param_enable_bit,
    output sepi_word_t       cam_flags_word,
    output sepi_word_t       preset_status_word,
    output sepi_word_t       velocity_word,
    output sepi_word_t       revolution_count_word,
    output sepi_word_t       single_turn_word,
    output logic             preset_go,
    output sepi_word_t       preset_rev_q,
    output sepi_word_t       preset_st_q
);

    // Outside-domain inputs pass two flops before use
    logic        locked_s1_q, locked_s2_q, locked_s1_d;
    logic        done_s1_q, done_s2_q;
    logic        par_s1_q, par_s2_q;
    logic        req_s1_q, req_s2_q;
    logic        req_prev_q, req_prev_d;

    // Signed velocity with direction applied
    logic signed [32:0] vel_signed;
    logic        ovf_d, ovf_q;
    sepi_word_t  vel_d, vel_q;
    logic [14:0] rev_d, rev_q;
    logic [12:0] st_d, st_q;
    logic [15:0] vel_abs;
    logic        slow_enough;
    logic [2:0]  tol_eff;

    sepi_state_t state_d, state_q;
    logic        pstat_d, pstat_q, err_d, err_q, go_d, go_q;
    sepi_word_t  prev_d, prev_q, pst_d, pst_q;

    // Velocity sign follows counting direction, in increments per period
    always_comb begin
        vel_signed = dir_forward ? {vel_cw_meas[31], vel_cw_meas} : -{vel_cw_meas[31], vel_cw_meas};
        locked_s1_d = other_preset_busy;
        req_prev_d  = req_s2_q;
        // Clamp at limits and flag overflow; clears on return
        if (vel_signed > 33'(`SEPI_VEL_MAX)) begin
            ovf_d = 1'b1;
            vel_d = `SEPI_VEL_POS_WORD;
        end else if (vel_signed < 33'(`SEPI_VEL_MIN)) begin
            ovf_d = 1'b1;
            vel_d = `SEPI_VEL_NEG_WORD;
        end else begin
            ovf_d = 1'b0;
            vel_d = vel_signed[15:0];
        end
        // Revolution count never exceeds 15-bit maximum
        if (rev_meas[31]) begin
            rev_d = 15'h0000;
        end else if (rev_meas > {17'h00000, `SEPI_REV_MAX}) begin
            rev_d = `SEPI_REV_MAX;
        end else begin
            rev_d = rev_meas[14:0];
        end
        st_d = single_turn_meas;
    end

    // Absolute speed vs tolerance; tolerance clipped to 1..5
    always_comb begin
        vel_abs = vel_q[15] ? 16'(-vel_q) : vel_q;
        if (idle_tolerance < `SEPI_TOL_MIN) begin
            tol_eff = `SEPI_TOL_MIN;
        end else if (idle_tolerance > `SEPI_TOL_MAX) begin
            tol_eff = `SEPI_TOL_MAX;
        end else begin
            tol_eff = idle_tolerance;
        end
        slow_enough = !ovf_q && (vel_abs <= {13'h0000, tol_eff});
    end

    // Preset handshake: rising request edge starts, done pulse ends
    always_comb begin
        state_d = state_q;
        pstat_d = pstat_q;
        err_d   = err_q;
        go_d    = 1'b0;
        prev_d  = prev_q;
        pst_d   = pst_q;
        case (state_q)
            SEPI_IDLE: begin
                if (req_s2_q && !req_prev_q) begin
                    pstat_d = 1'b1;
                    if (locked_s2_q) begin
                        state_d = SEPI_IDLE;
                        pstat_d = 1'b0;
                    end else if (!slow_enough) begin
                        err_d   = 1'b1;
                        pstat_d = 1'b0;
                        state_d = SEPI_FAIL;
                    end else begin
                        go_d    = 1'b1;
                        prev_d  = preset_rev_word;
                        pst_d   = preset_st_word;
                        state_d = SEPI_BUSY;
                    end
                end
            end
            SEPI_BUSY: begin
                if (done_s2_q) begin
                    pstat_d = 1'b0;
                    state_d = SEPI_IDLE;
                end
            end
            SEPI_FAIL: begin
                // Error held until host drops parameter enable
                if (!par_s2_q) begin
                    err_d   = 1'b0;
                    state_d = SEPI_IDLE;
                end
            end
            default: begin
                state_d = SEPI_IDLE;
            end
        endcase
    end

    // All state frozen while ce is low
    always_ff @(posedge mclk) begin
        if (rst) begin
            locked_s1_q <= 1'b0;
            locked_s2_q <= 1'b0;
            done_s1_q   <= 1'b0;
            done_s2_q   <= 1'b0;
            par_s1_q    <= 1'b0;
            par_s2_q    <= 1'b0;
            req_s1_q    <= 1'b0;
            req_s2_q    <= 1'b0;
            req_prev_q  <= 1'b0;
            ovf_q       <= 1'b0;
            vel_q       <= `SEPI_WORD_ZERO;
            rev_q       <= 15'h0000;
            st_q        <= 13'h0000;
            state_q     <= SEPI_IDLE;
            pstat_q     <= 1'b0;
            err_q       <= 1'b0;
            go_q        <= 1'b0;
            prev_q      <= `SEPI_WORD_ZERO;
            pst_q       <= `SEPI_WORD_ZERO;
        end else if (ce) begin
            locked_s1_q <= locked_s1_d;
            locked_s2_q <= locked_s1_q;
            done_s1_q   <= preset_done;
            done_s2_q   <= done_s1_q;
            par_s1_q    <= param_enable_bit;
            par_s2_q    <= par_s1_q;
            req_s1_q    <= preset_control_word[`SEPI_BIT_PRESET];
            req_s2_q    <= req_s1_q;
            req_prev_q  <= req_prev_d;
            ovf_q       <= ovf_d;
            vel_q       <= vel_d;
            rev_q       <= rev_d;
            st_q        <= st_d;
            state_q     <= state_d;
            pstat_q     <= pstat_d;
            err_q       <= err_d;
            go_q        <= go_d;
            prev_q      <= prev_d;
            pst_q       <= pst_d;
        end
    end

    // Output words straight from flops; reserved bits zero
    always_comb begin
        cam_flags_word = `SEPI_WORD_ZERO;
        cam_flags_word[`SEPI_BIT_OVF] = ovf_q;
        preset_status_word = `SEPI_WORD_ZERO;
        preset_status_word[`SEPI_BIT_PRESET] = pstat_q;
        preset_status_word[`SEPI_BIT_LOCKED] = locked_s2_q;
        preset_status_word[`SEPI_BIT_ERROR]  = err_q;
        velocity_word         = vel_q;
        revolution_count_word = {1'b0, rev_q};
        single_turn_word      = {3'b000, st_q};
        preset_go             = go_q;
        preset_rev_q          = prev_q;
        preset_st_q           = pst_q;
    end

    // Assertion helpers: a request edge reaching the idle handshake
    sequence seq_req_edge_idle;
        !rst && ce && state_q == SEPI_IDLE && req_s2_q && !req_prev_q;
    endsequence

    // Request edge that passes both the lock and the speed gate
    sequence seq_req_accepted;
        seq_req_edge_idle ##0 (!locked_s2_q && slow_enough);
    endsequence

    // Request edge free of the lock but too fast to preset
    sequence seq_req_too_fast;
        seq_req_edge_idle ##0 (!locked_s2_q && !slow_enough);
    endsequence

    // Preset start as the host sees it: go pulse with status bit 0 up
    sequence seq_preset_started;
        preset_go && preset_status_word[`SEPI_BIT_PRESET];
    endsequence

    // Clamped velocity pairs with overflow flag; the reset edge itself is skipped
    chk_vel_clamp_pos: assert property (@(posedge mclk) disable iff (rst)
        !rst && ce && vel_signed > 33'(`SEPI_VEL_MAX)
        |=> velocity_word == `SEPI_VEL_POS_WORD && cam_flags_word[`SEPI_BIT_OVF])
        else $error("velocity not clamped high");
    chk_vel_clamp_neg: assert property (@(posedge mclk) disable iff (rst)
        !rst && ce && vel_signed < 33'(`SEPI_VEL_MIN)
        |=> velocity_word == `SEPI_VEL_NEG_WORD && cam_flags_word[`SEPI_BIT_OVF])
        else $error("velocity not clamped low");
    // Back in range the true value shows again, flag down
    chk_ovf_clear_in: assert property (@(posedge mclk) disable iff (rst)
        !rst && ce && !ovf_d
        |=> !cam_flags_word[`SEPI_BIT_OVF] && velocity_word == $past(vel_signed[15:0]))
        else $error("overflow not cleared");

    // Revolution word never reaches bit 15
    chk_rev_range_ok: assert property (@(posedge mclk) disable iff (rst)
        !revolution_count_word[15])
        else $error("revolution word above 15 bits");

    // A lock from the other module blocks the go pulse and shows in bit 9
    chk_locked_no_go: assert property (@(posedge mclk) disable iff (rst)
        !rst && ce && locked_s2_q && state_q == SEPI_IDLE |=> !preset_go)
        else $error("preset run while locked");
    chk_locked_shown: assert property (@(posedge mclk) disable iff (rst)
        !rst && ce |=> preset_status_word[`SEPI_BIT_LOCKED] == $past(locked_s1_q))
        else $error("lock bit not shown");

    // Too fast: error raised and no go pulse
    chk_fast_err_set: assert property (@(posedge mclk) disable iff (rst)
        seq_req_too_fast |=> preset_status_word[`SEPI_BIT_ERROR] && !preset_go)
        else $error("fast preset not rejected");
    // Slow and free: go pulse one edge after the request edge
    chk_go_on_accept: assert property (@(posedge mclk) disable iff (rst)
        seq_req_accepted |=> seq_preset_started)
        else $error("accepted preset did not start");
    // Preset value taken from the host words at the start
    chk_preset_capture: assert property (@(posedge mclk) disable iff (rst)
        seq_req_accepted |=> preset_rev_q == $past(preset_rev_word) && preset_st_q == $past(preset_st_word))
        else $error("preset value not captured");
    // Go is a single pulse, so a request left high cannot run twice
    chk_go_one_pulse: assert property (@(posedge mclk) disable iff (rst)
        !rst && ce && preset_go |=> !preset_go)
        else $error("go pulse longer than one cycle");

    // Status bit 0 raised with go and dropped once the preset is done
    chk_busy_status: assert property (@(posedge mclk) disable iff (rst)
        preset_go |-> preset_status_word[`SEPI_BIT_PRESET])
        else $error("status bit 0 not set during preset");
    chk_done_clears: assert property (@(posedge mclk) disable iff (rst)
        !rst && ce && state_q == SEPI_BUSY && done_s2_q |=> !preset_status_word[`SEPI_BIT_PRESET])
        else $error("status bit 0 not cleared after preset");

    // Error stays until the host drops parameter enable, then clears
    chk_err_hold_par: assert property (@(posedge mclk) disable iff (rst)
        !rst && preset_status_word[`SEPI_BIT_ERROR] && par_s2_q |=> preset_status_word[`SEPI_BIT_ERROR])
        else $error("error cleared early");
    chk_err_clear_ack: assert property (@(posedge mclk) disable iff (rst)
        !rst && ce && state_q == SEPI_FAIL && !par_s2_q |=> !preset_status_word[`SEPI_BIT_ERROR])
        else $error("error not cleared after acknowledge");

    // Reserved bits of the cam and status words read zero
    chk_reserved_zero: assert property (@(posedge mclk) disable iff (rst)
        cam_flags_word[15:1] == 15'h0000 && preset_status_word[8:1] == 8'h00
        && preset_status_word[14:10] == 5'h00)
        else $error("reserved bits set");

    // Clock enable low leaves the velocity, status and cam words untouched
    chk_ce_freeze: assert property (@(posedge mclk) disable iff (rst)
        !rst && !ce |=> $stable(velocity_word) && $stable(preset_status_word) && $stable(cam_flags_word))
        else $error("image changed while clock enable low");

endmodule // sepi_image

// file: shared/sepi_params.svh
// Constants for the safety encoder process image block
`ifndef SEPI_PARAMS_SVH
`define SEPI_PARAMS_SVH
`define SEPI_VEL_MAX        32'sh00007fff
`define SEPI_VEL_MIN       -32'sh00008000
`define SEPI_VEL_POS_WORD   16'h7fff
`define SEPI_VEL_NEG_WORD   16'h8000
`define SEPI_BIT_OVF        0
`define SEPI_BIT_PRESET     0
`define SEPI_BIT_LOCKED     9
`define SEPI_BIT_ERROR      15
`define SEPI_BIT_PAR_EN     0
`define SEPI_REV_MAX        15'h7fff
`define SEPI_ST_BITS        13
`define SEPI_TOL_MIN        3'h1
`define SEPI_TOL_MAX        3'h5
`define SEPI_WORD_ZERO      16'h0000
`endif

// file: shared/sepi_pkg.sv
// Types for the safety encoder process image block
package sepi_pkg;
    typedef logic [15:0] sepi_word_t;
    typedef enum logic [1:0] {
        SEPI_IDLE,
        SEPI_BUSY,
        SEPI_FAIL
    } sepi_state_t;
endpackage

// file: verif/sepi_fhost.sv
// Behavioural safety controller that drives the four output words
`timescale 1ns/1ps
module sepi_fhost
    import sepi_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       req,
    input  wire logic       par_en,
    input  wire sepi_word_t rev_in,
    input  wire sepi_word_t st_in,
    output sepi_word_t      preset_control_word,
    output sepi_word_t      reserved_control_word,
    output sepi_word_t      preset_rev_word,
    output sepi_word_t      preset_st_word,
    output logic            param_enable_bit
);
    // Whole frame refreshed every cycle; reserved word toggles so ignoring it is tested
    always_ff @(posedge mclk) begin
        preset_control_word   <= {15'h0000, req & ~rst};
        reserved_control_word <= rst ? 16'h0000 : ~reserved_control_word;
        preset_rev_word       <= rev_in;
        preset_st_word        <= st_in;
        param_enable_bit      <= par_en & ~rst;
    end
endmodule // sepi_fhost

// file: verif/tb_top.sv
// Self-checking bench for the safety encoder process image
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top
    import sepi_pkg::*;
;
    logic        mclk, rst, ce, dir_fwd, busy, done, req, par_en, pen, go;
    logic [31:0] vel, rev;
    logic [12:0] st;
    logic [2:0]  tol;
    sepi_word_t  rev_in, st_in, pcw, rcw, prw, psw, cam, stat, velw, revw, stw, prq, psq;
    int          n_mismatch, samples_checked;

    sepi_fhost host (.mclk(mclk), .rst(rst), .req(req), .par_en(par_en), .rev_in(rev_in),
        .st_in(st_in), .preset_control_word(pcw), .reserved_control_word(rcw),
        .preset_rev_word(prw), .preset_st_word(psw), .param_enable_bit(pen));
    sepi_image dut (.mclk(mclk), .rst(rst), .ce(ce), .vel_cw_meas(vel), .dir_forward(dir_fwd),
        .idle_tolerance(tol), .rev_meas(rev), .single_turn_meas(st), .other_preset_busy(busy),
        .preset_done(done), .preset_control_word(pcw), .reserved_control_word(rcw),
        .preset_rev_word(prw), .preset_st_word(psw), .param_enable_bit(pen),
        .cam_flags_word(cam), .preset_status_word(stat), .velocity_word(velw),
        .revolution_count_word(revw), .single_turn_word(stw), .preset_go(go),
        .preset_rev_q(prq), .preset_st_q(psq));

    task automatic final_report;
        if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Bounded watch for the go pulse; a missing pulse ends the run
    task automatic wait_go(input bit expect_go);
        bit seen;
        seen = 0;
        for (int i = 0; i < 12 && !seen; i++) begin
            @(negedge mclk);
            seen = (go === 1'b1);
        end
        `CHK(seen, expect_go)
        if (expect_go && !seen) final_report;
    endtask

    // Sign, direction and clamping, both limits and the way back
    task automatic t_velocity;
        logic [31:0] v [6] = '{32'h00001234, 32'h00001234, 32'h00008000,
                               32'hffff7fff, 32'h00007fff, 32'hffff8000};
        logic        d [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
        sepi_word_t  ev [6] = '{16'h1234, 16'hedcc, 16'h7fff, 16'h8000, 16'h7fff, 16'h8000};
        sepi_word_t  ec [6] = '{16'h0000, 16'h0000, 16'h0001, 16'h0001, 16'h0000, 16'h0000};
        for (int i = 0; i < 6; i++) begin
            @(posedge mclk);
            vel <= v[i];
            dir_fwd <= d[i];
            cyc(3);
            @(negedge mclk);
            `CHK(velw, ev[i])
            `CHK(cam, ec[i])
        end
    endtask

    // Revolution clamping at both ends and single-turn width
    task automatic t_position;
        logic [31:0] r [3] = '{32'd40000, 32'hfffffffb, 32'd1234};
        logic [12:0] s [3] = '{13'h1fff, 13'h0005, 13'h0000};
        sepi_word_t  er [3] = '{16'h7fff, 16'h0000, 16'h04d2};
        sepi_word_t  es [3] = '{16'h1fff, 16'h0005, 16'h0000};
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk);
            rev <= r[i];
            st <= s[i];
            cyc(3);
            @(negedge mclk);
            `CHK(revw, er[i])
            `CHK(stw, es[i])
        end
    endtask

    // Request, done handshake; ends with the request and done released
    task automatic do_preset;
        @(posedge mclk);
        req <= 1'b1;
        wait_go(1'b1);
        `CHK(stat, 16'h0001)
        `CHK(prq, rev_in)
        `CHK(psq, st_in)
        @(posedge mclk);
        req <= 1'b0;
        done <= 1'b1;
        @(posedge mclk);
        done <= 1'b0;
        cyc(5);
        @(negedge mclk);
        `CHK(stat, 16'h0000)
    endtask

    // Speed exactly at the largest tolerance is accepted
    task automatic t_preset_ok;
        @(posedge mclk);
        vel <= 32'd5;
        tol <= 3'h5;
        rev_in <= 16'h0123;
        st_in <= 16'h1abc;
        cyc(3);
        do_preset();
    endtask

    // Another module presetting locks this one out
    task automatic t_locked;
        @(posedge mclk);
        busy <= 1'b1;
        cyc(4);
        req <= 1'b1;
        wait_go(1'b0);
        `CHK(stat, 16'h0200)
        @(posedge mclk);
        req <= 1'b0;
        busy <= 1'b0;
        cyc(4);
        @(negedge mclk);
        `CHK(stat, 16'h0000)
    endtask

    // One increment above tolerance: error held until acknowledged, then retry
    task automatic t_too_fast;
        @(posedge mclk);
        vel <= 32'd6;
        cyc(3);
        req <= 1'b1;
        wait_go(1'b0);
        `CHK(stat, 16'h8000)
        @(posedge mclk);
        req <= 1'b0;
        cyc(6);
        @(negedge mclk);
        `CHK(stat, 16'h8000)
        @(posedge mclk);
        par_en <= 1'b0;
        cyc(6);
        @(negedge mclk);
        `CHK(stat, 16'h0000)
        @(posedge mclk);
        par_en <= 1'b1;
        vel <= 32'd1;
        tol <= 3'h1;
        rev_in <= 16'h0042;
        cyc(4);
        do_preset();
    endtask

    // Clock enable low freezes the image; a reset in mid-run clears it
    task automatic t_freeze_reset;
        @(posedge mclk);
        ce <= 1'b0;
        vel <= 32'd100;
        busy <= 1'b1;
        cyc(6);
        @(negedge mclk);
        `CHK(velw, 16'h0001)
        `CHK(stat, 16'h0000)
        @(posedge mclk);
        ce <= 1'b1;
        cyc(4);
        @(negedge mclk);
        `CHK(velw, 16'h0064)
        `CHK(stat, 16'h0200)
        @(posedge mclk);
        rst <= 1'b1;
        cyc(2);
        @(negedge mclk);
        `CHK({cam, stat, velw, revw}, 64'h0000_0000_0000_0000)
        `CHK({stw, prq, psq, 15'h0000, go}, 64'h0000_0000_0000_0000)
        @(posedge mclk);
        rst <= 1'b0;
        busy <= 1'b0;
        cyc(3);
        @(negedge mclk);
        `CHK(velw, 16'h0064)
        `CHK({revw, stw, stat}, 48'h04d2_0000_0000)
    endtask

    // Free-running clock, 8 ns period
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // Reset, then the scenarios in turn
    initial begin
        {rst, ce, dir_fwd, par_en} = 4'hf;
        {busy, done, req} = 3'h0;
        {vel, rev, st, tol} = '0;
        rev_in = 16'h0000;
        st_in = 16'h0000;
        n_mismatch = 0;
        samples_checked = 0;
        cyc(8);
        rst <= 1'b0;
        t_velocity();
        t_position();
        t_preset_ok();
        t_locked();
        t_too_fast();
        t_freeze_reset();
        final_report();
    end
endmodule // tb_top
